// ### dmx_pkg.sv
// Purpose: Shared constants and types for the four-channel block mover
// Assumes: One clock, pclk, for both ends
// Notes:   Offsets are APB byte addresses, one aligned word per register
package dmx_pkg;
   localparam int NCH  = 4;
   localparam int NSRC = 256;
   localparam int CNTW = 14;
   localparam int NPER = 7;
   // Register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_REQ  = 8'h04;
   localparam logic [7:0] OFF_STA  = 8'h08;
   localparam logic [7:0] OFF_STB  = 8'h0c;
   localparam logic [7:0] OFF_PAD  = 8'h10;
   localparam logic [7:0] OFF_CNT  = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h80;
   // Control, request and status field positions
   localparam int CF_EN   = 0;
   localparam int CF_DIR  = 1;
   localparam int CF_BYTE = 2;
   localparam int CF_AM   = 3;
   localparam int CF_RPT  = 5;
   localparam int CF_PP   = 6;
   localparam int CF_HALF = 7;
   localparam int RQ_FORCE = 15;
   localparam int ST_BUSY  = 12;
   // Addressing modes
   localparam logic [1:0] AM_INC  = 2'h0;
   localparam logic [1:0] AM_HOLD = 2'h1;
   localparam logic [1:0] AM_PIA  = 2'h2;
   // Reset values
   localparam logic [7:0]      CTRL_RST = 8'h00;
   localparam logic [7:0]      SEL_RST  = 8'h00;
   localparam logic [15:0]     ADDR_RST = 16'h0000;
   localparam logic [CNTW-1:0] CNT_RST  = 14'h0000;
   // Request codes
   localparam logic [7:0] SEL_EXT0   = 8'h00;
   localparam logic [7:0] SEL_S1_RX  = 8'h0b;
   localparam logic [7:0] SEL_S1_TX  = 8'h0c;
   localparam logic [7:0] SEL_S2_RX  = 8'h1e;
   localparam logic [7:0] SEL_S2_TX  = 8'h1f;
   localparam logic [7:0] SEL_CAN_RX = 8'h22;
   localparam logic [7:0] SEL_CAN_TX = 8'h46;
   localparam logic [7:0] SEL_CONV   = 8'h0d;
   // Peripheral data addresses
   localparam logic [15:0] ADR_S1_RX  = 16'h0226;
   localparam logic [15:0] ADR_S1_TX  = 16'h0224;
   localparam logic [15:0] ADR_S2_RX  = 16'h0236;
   localparam logic [15:0] ADR_S2_TX  = 16'h0234;
   localparam logic [15:0] ADR_CAN_RX = 16'h0440;
   localparam logic [15:0] ADR_CAN_TX = 16'h0442;
   localparam logic [15:0] ADR_CONV   = 16'h0300;
   localparam logic [15:0] PER_ADDR [NPER] = '{ADR_S1_RX, ADR_S1_TX, ADR_S2_RX,
      ADR_S2_TX, ADR_CAN_RX, ADR_CAN_TX, ADR_CONV};
   localparam logic [7:0] PER_CODE [NPER] = '{SEL_S1_RX, SEL_S1_TX, SEL_S2_RX,
      SEL_S2_TX, SEL_CAN_RX, SEL_CAN_TX, SEL_CONV};
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dmx_state_t;
endpackage

// ### dmx_if.sv
// Purpose: Link between the block mover and the system it serves
// Assumes: Both ends on pclk
// Notes:   Memory port is request held until a one-cycle ack
interface dmx_if;
   import dmx_pkg::*;
   logic [NSRC-1:0]  src_ev;
   logic [15:0]      pia_addr [NCH];
   logic             mem_req;
   logic             mem_we;
   logic             mem_per;
   logic             mem_byte;
   logic [15:0]      mem_addr;
   logic [15:0]      mem_wdata;
   logic [15:0]      mem_rdata;
   logic             mem_ack;
   logic [NCH-1:0]   blk_irq;
   modport dma (input src_ev, pia_addr, mem_rdata, mem_ack,
                output mem_req, mem_we, mem_per, mem_byte, mem_addr, mem_wdata, blk_irq);
   modport sys (output src_ev, pia_addr, mem_rdata, mem_ack,
                input mem_req, mem_we, mem_per, mem_byte, mem_addr, mem_wdata, blk_irq);
endinterface

// ### dmx_arb.sv
// Purpose: Fixed priority pick among pending channels
// Assumes: Requests are held until granted
// Notes:   Lowest index wins
module dmx_arb #(
   parameter int N = 4
) (
   // Requests
   input  wire logic [N-1:0]         req,
   // Winner
   output logic      [N-1:0]         gnt,
   output logic      [$clog2(N)-1:0] idx,
   output logic                      any
);
   always_comb begin
      gnt = '0;
      idx = '0;
      any = |req;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            gnt    = '0;
            gnt[i] = 1'b1; // R3 R22
            idx    = ($clog2(N))'(i);
         end
      end
   end
endmodule // dmx_arb

// ### dmx_sys.sv
// Purpose: System end: SRAM, peripheral data slots, request lines
// Assumes: One request at a time from the mover
// Notes:   Ack follows a request by one cycle
module dmx_sys import dmx_pkg::*; #(
   parameter int SRAM_WORDS = 4096
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Link
   dmx_if.sys                     bus,
   // Event sources and indirect addresses
   input  wire logic [NSRC-1:0]   ev_in,
   input  wire logic [15:0]       pia_in [NCH],
   // Peripheral produces data
   input  wire logic              per_ld,
   input  wire logic [15:0]       per_ld_addr,
   input  wire logic [15:0]       per_ld_data,
   // Peripheral consumes data
   output logic                   tx_stb,
   output logic      [15:0]       tx_addr,
   output logic      [15:0]       tx_data,
   // Block or half-block event to the CPU, as the channel's half bit selects
   output logic      [NCH-1:0]    blk_done
);
   localparam int SAW = $clog2(SRAM_WORDS);
   logic [15:0]     sram [SRAM_WORDS];
   logic [15:0]     per_q [NPER];
   logic [NSRC-1:0] ld_ev_q;
   logic            ack_q;
   logic [15:0]     rdata_q;
   logic [15:0]     word;
   logic [SAW-1:0]  wi;

   function automatic logic [2:0] slot_of(input logic [15:0] a);
      slot_of = 3'h7;
      for (int s = 0; s < NPER; s++) begin
         if (a == PER_ADDR[s]) slot_of = 3'(s);
      end
   endfunction

   assign wi           = bus.mem_addr[SAW:1];
   assign bus.src_ev   = ev_in | ld_ev_q;
   assign bus.pia_addr = pia_in; // R7
   assign bus.mem_ack  = ack_q;
   assign bus.mem_rdata = rdata_q;

   always_comb begin
      if (bus.mem_per) begin
         word = (slot_of(bus.mem_addr) == 3'h7) ? 16'h0000 : per_q[slot_of(bus.mem_addr)];
      end else begin
         word = sram[wi];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q   <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q <= bus.mem_req & ~ack_q;
         if (bus.mem_byte && bus.mem_addr[0]) begin
            rdata_q <= {8'h00, word[15:8]};
         end else if (bus.mem_byte) begin
            rdata_q <= {8'h00, word[7:0]};
         end else begin
            rdata_q <= word;
         end
      end
   end

   // Memory has no reset; contents are undefined until written
   always_ff @(posedge pclk) begin
      if (bus.mem_req && !ack_q && bus.mem_we && !bus.mem_per) begin
         if (!bus.mem_byte || !bus.mem_addr[0]) sram[wi][7:0] <= bus.mem_wdata[7:0];
         if (!bus.mem_byte || bus.mem_addr[0]) begin
            sram[wi][15:8] <= bus.mem_byte ? bus.mem_wdata[7:0] : bus.mem_wdata[15:8];
         end
      end
   end

   // Receive slots raise their own request code when loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_ev_q <= '0;
         for (int s = 0; s < NPER; s++) per_q[s] <= 16'h0000;
      end else begin
         ld_ev_q <= '0;
         if (per_ld && slot_of(per_ld_addr) != 3'h7) begin
            per_q[slot_of(per_ld_addr)] <= per_ld_data; // R14 R16 R18 R20
            ld_ev_q[PER_CODE[slot_of(per_ld_addr)]] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_stb   <= 1'b0;
         tx_addr  <= 16'h0000;
         tx_data  <= 16'h0000;
         blk_done <= '0;
      end else begin
         tx_stb   <= bus.mem_req & ~ack_q & bus.mem_we & bus.mem_per; // R15 R17 R19
         // Slot contents stand until the next peripheral write
         if (bus.mem_req && !ack_q && bus.mem_we && bus.mem_per) begin
            tx_addr <= bus.mem_addr;
            tx_data <= bus.mem_wdata;
         end
         blk_done <= bus.blk_irq;
      end
   end
endmodule // dmx_sys

// ### dmx_ctrl.sv
// Purpose: Four-channel block mover between SRAM and peripheral data slots
// Assumes: APB slave with zero wait states; one clock
// Notes:   Each move is a read then a write over the link memory port
// How it works
// R1: each channel moves in one direction only
// R2: software uses two channels for both directions
// R3: fixed channel priority picks one, others wait
// R4: block done raises a CPU interrupt pulse
// R5: interrupt at half block or full block
// R6: SRAM address post-increment or held
// R7: peripheral supplies address in indirect mode
// R8: byte or 16-bit word per transfer
// R9: software force or peripheral request starts transfer
// R10: one-shot stops, auto-repeat rearms
// R11: ping-pong swaps SRAM start address per block
// R12: 8-bit code selects request source
// R13: code zero selects external interrupt zero
// R14: code 0b selects serial1 receive at 0226
// R15: code 0c selects serial1 transmit at 0224
// R16: code 1e selects serial2 receive at 0236
// R17: code 1f selects serial2 transmit at 0234
// R18: code 22 selects CAN receive at 0440
// R19: code 46 selects CAN transmit at 0442
// R20: code 0d selects converter result at 0300
// R21: timers and external interrupts also trigger
// R22: lowest channel wins, losers stay latched
// R23: one transfer per grant, count and address advance
module dmx_ctrl import dmx_pkg::*; (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Register bus
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   dmx_if.dma               bus
);
   logic [7:0]      ctrl_q [NCH];
   logic [7:0]      sel_q  [NCH];
   logic [15:0]     sta_q  [NCH];
   logic [15:0]     stb_q  [NCH];
   logic [15:0]     pad_q  [NCH];
   logic [CNTW-1:0] cnt_q  [NCH];
   logic [CNTW-1:0] idx_q  [NCH];
   logic [NCH-1:0]  pend_q, pp_q, done_q, half_q, irq_q;
   logic [NCH-1:0]  set_ev, fsw, gnt;
   logic [1:0]      gidx, ch_q, rc;
   logic            any, take, fin, wr, err_d;
   dmx_state_t      state_q;
   logic [15:0]     addr_q, dst_q, data_q, sram_a, off;
   logic            we_q, per_q, byte_q;
   logic [31:0]     rd_d;

   function automatic logic ch_reg(input logic [7:0] a, input logic [7:0] o);
      ch_reg = !a[7] && a[4:0] == o[4:0];
   endfunction

   assign rc     = paddr[6:5];
   assign wr     = psel & penable & pwrite;
   assign pready = 1'b1;
   assign take   = (state_q == ST_IDLE) & any;
   assign fin    = (state_q == ST_WR) & bus.mem_ack;

   // Requests: selected source or forced by software
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         fsw[i]    = wr & ch_reg(paddr, OFF_REQ) & (rc == 2'(i)) & pwdata[RQ_FORCE]; // R9
         set_ev[i] = ctrl_q[i][CF_EN] & (bus.src_ev[sel_q[i]] | fsw[i]); // R12 R13 R21
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= '0;
      end else begin
         pend_q <= set_ev | (pend_q & ~(gnt & {NCH{take}})); // R22
      end
   end

   dmx_arb #(.N(NCH)) u_arb (
      .req (pend_q),
      .gnt (gnt),
      .idx (gidx),
      .any (any)
   );

   // SRAM side address of the winner
   always_comb begin
      unique case (ctrl_q[gidx][CF_AM+:2])
         AM_PIA:  off = bus.pia_addr[gidx]; // R7
         AM_HOLD: off = 16'h0000; // R6
         default: off = ctrl_q[gidx][CF_BYTE] ? 16'(idx_q[gidx]) : 16'({idx_q[gidx], 1'b0}); // R6 R8
      endcase
      sram_a = (pp_q[gidx] ? stb_q[gidx] : sta_q[gidx]) + off; // R11
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         ch_q    <= 2'h0;
         addr_q  <= 16'h0000;
         dst_q   <= 16'h0000;
         data_q  <= 16'h0000;
         we_q    <= 1'b0;
         per_q   <= 1'b0;
         byte_q  <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: if (take) begin
               ch_q   <= gidx;
               byte_q <= ctrl_q[gidx][CF_BYTE]; // R8
               we_q   <= 1'b0;
               // Direction fixed per channel
               per_q  <= ~ctrl_q[gidx][CF_DIR]; // R1
               addr_q <= ctrl_q[gidx][CF_DIR] ? sram_a : pad_q[gidx];
               dst_q  <= ctrl_q[gidx][CF_DIR] ? pad_q[gidx] : sram_a;
               state_q <= ST_RD;
            end
            ST_RD: if (bus.mem_ack) begin
               data_q  <= bus.mem_rdata;
               addr_q  <= dst_q;
               we_q    <= 1'b1;
               per_q   <= ctrl_q[ch_q][CF_DIR];
               state_q <= ST_WR;
            end
            ST_WR: if (bus.mem_ack) begin
               we_q    <= 1'b0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign bus.mem_req   = state_q != ST_IDLE;
   assign bus.mem_we    = we_q;
   assign bus.mem_per   = per_q;
   assign bus.mem_byte  = byte_q;
   assign bus.mem_addr  = addr_q;
   assign bus.mem_wdata = data_q;
   assign bus.blk_irq   = irq_q;

   // Block progress, completion and rearm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) idx_q[i] <= CNT_RST;
         pp_q  <= '0;
         irq_q <= '0;
      end else begin
         irq_q <= '0;
         if (fin) begin
            if (idx_q[ch_q] == cnt_q[ch_q]) begin
               idx_q[ch_q] <= CNT_RST;
               irq_q[ch_q] <= ~ctrl_q[ch_q][CF_HALF]; // R4 R5
               if (ctrl_q[ch_q][CF_PP]) pp_q[ch_q] <= ~pp_q[ch_q]; // R11
            end else begin
               idx_q[ch_q] <= idx_q[ch_q] + 1'b1; // R23
               if (idx_q[ch_q] == (cnt_q[ch_q] >> 1)) begin
                  irq_q[ch_q] <= ctrl_q[ch_q][CF_HALF]; // R5
               end
            end
         end
      end
   end

   // Sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= '0;
         half_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr && paddr == OFF_STAT && pwdata[i]) done_q[i] <= 1'b0;
            if (wr && paddr == OFF_STAT && pwdata[NCH+i]) half_q[i] <= 1'b0;
            if (fin && ch_q == 2'(i) && idx_q[i] == cnt_q[i]) done_q[i] <= 1'b1;
            if (fin && ch_q == 2'(i) && idx_q[i] == (cnt_q[i] >> 1)) half_q[i] <= 1'b1;
         end
      end
   end

   // Channel configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            ctrl_q[i] <= CTRL_RST;
            sel_q[i]  <= SEL_RST;
            sta_q[i]  <= ADDR_RST;
            stb_q[i]  <= ADDR_RST;
            pad_q[i]  <= ADDR_RST;
            cnt_q[i]  <= CNT_RST;
         end
      end else begin
         // One-shot ends the channel; repeat keeps it armed
         if (fin && idx_q[ch_q] == cnt_q[ch_q] && !ctrl_q[ch_q][CF_RPT]) begin
            ctrl_q[ch_q][CF_EN] <= 1'b0; // R10
         end
         if (wr && ch_reg(paddr, OFF_CTRL)) ctrl_q[rc] <= pwdata[7:0];
         if (wr && ch_reg(paddr, OFF_REQ)) sel_q[rc] <= pwdata[7:0]; // R12
         if (wr && ch_reg(paddr, OFF_STA)) sta_q[rc] <= pwdata[15:0];
         if (wr && ch_reg(paddr, OFF_STB)) stb_q[rc] <= pwdata[15:0];
         if (wr && ch_reg(paddr, OFF_PAD)) pad_q[rc] <= pwdata[15:0];
         if (wr && ch_reg(paddr, OFF_CNT)) cnt_q[rc] <= pwdata[CNTW-1:0];
      end
   end

   // Read data is fetched in the setup cycle so prdata comes from a flop
   always_comb begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if (paddr == OFF_STAT) begin
         rd_d = {19'h0, state_q != ST_IDLE, pp_q, half_q, done_q};
      end else if (ch_reg(paddr, OFF_CTRL)) begin
         rd_d = {24'h0, ctrl_q[rc]};
      end else if (ch_reg(paddr, OFF_REQ)) begin
         rd_d = {24'h0, sel_q[rc]};
      end else if (ch_reg(paddr, OFF_STA)) begin
         rd_d = {16'h0, sta_q[rc]};
      end else if (ch_reg(paddr, OFF_STB)) begin
         rd_d = {16'h0, stb_q[rc]};
      end else if (ch_reg(paddr, OFF_PAD)) begin
         rd_d = {16'h0, pad_q[rc]};
      end else if (ch_reg(paddr, OFF_CNT)) begin
         rd_d = {18'h0, cnt_q[rc]};
      end else begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_d;
         pslverr <= err_d;
      end
   end
endmodule // dmx_ctrl

// ### dmx_checker.sv
// Purpose: Link protocol checks between mover and system end
// Assumes: One clock; reset asynchronous, active low
// Notes:   Takes link signals as plain inputs, instanced beside the link
module dmx_checker import dmx_pkg::*; (
   // Clock and reset
   input wire logic           pclk,
   input wire logic           presetn,
   // Link
   input wire logic           mem_req,
   input wire logic           mem_we,
   input wire logic           mem_per,
   input wire logic           mem_byte,
   input wire logic [15:0]    mem_addr,
   input wire logic [15:0]    mem_wdata,
   input wire logic           mem_ack,
   input wire logic [NCH-1:0] blk_irq
);
   logic wr_seen_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Remembers a finished write, the only cause of a block event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wr_seen_q <= 1'b0;
      else
         wr_seen_q <= mem_req & mem_we & mem_ack;
   end

   sequence rd_done_s;
      mem_req && !mem_we && mem_ack;
   endsequence
   sequence wr_done_s;
      mem_req && mem_we && mem_ack;
   endsequence

   ack_timing_a: assert property (mem_req && !mem_ack |=> mem_ack)
      else $error("link ack not one cycle after request");
   ack_pulse_a: assert property (mem_ack |=> !mem_ack)
      else $error("link ack longer than one cycle");
   req_hold_a: assert property (mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_per) && $stable(mem_wdata))
      else $error("link request changed before ack");
   rd_wr_order_a: assert property (rd_done_s |=> mem_req && mem_we
      && mem_per != $past(mem_per))
      else $error("read not followed by write to the other space");
   one_move_a: assert property (wr_done_s |=> !mem_req)
      else $error("request held after the write");
   word_align_a: assert property (mem_req && !mem_byte |-> !mem_addr[0])
      else $error("odd address in word mode");
   irq_cause_a: assert property (|blk_irq |-> wr_seen_q)
      else $error("block event without a finished write");
   irq_pulse_a: assert property (|blk_irq |-> $onehot(blk_irq) ##1 blk_irq == '0)
      else $error("block event not a single one-cycle pulse");
endmodule // dmx_checker

// ### dmx_ctrl_test.sv
// Purpose: Self-checking bench joining both ends of the block mover
// Assumes: Zero-wait APB slave; link ack one cycle after request
// Notes:   SRAM addresses are watched on the link, data at the transmit slot
module dmx_ctrl_test import dmx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Inc word, hold byte, half repeat, indirect, ping-pong repeat
   localparam logic [7:0] TCTL [5] = '{8'h03, 8'h0f, 8'ha7, 8'h13, 8'h63};
   localparam int         TCNT [5] = '{3, 1, 3, 0, 0};
   localparam int         TREQ [5] = '{5, 2, 8, 1, 3};
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ld, tx_stb;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd, v;
   logic [NSRC-1:0]  ev;
   logic [15:0]      pia [NCH];
   logic [15:0]      ld_addr, ld_data, tx_addr, tx_data, sa, sb, dat;
   logic [NCH-1:0]   blk_done;
   logic [15:0]      sram_q [$];
   int               num_errors, check_count, seed, ntr, tx, done_cnt [NCH];

   dmx_if link();
   dmx_ctrl u_dmx_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(link.dma));
   dmx_sys u_dmx_sys (.pclk(pclk), .presetn(presetn), .bus(link.sys), .ev_in(ev),
      .pia_in(pia), .per_ld(ld), .per_ld_addr(ld_addr), .per_ld_data(ld_data),
      .tx_stb(tx_stb), .tx_addr(tx_addr), .tx_data(tx_data), .blk_done(blk_done));
   dmx_checker u_dmx_checker (.pclk(pclk), .presetn(presetn), .mem_req(link.mem_req),
      .mem_we(link.mem_we), .mem_per(link.mem_per), .mem_byte(link.mem_byte),
      .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .mem_ack(link.mem_ack),
      .blk_irq(link.blk_irq));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Pre-edge values, so address and ack belong to one cycle
   always @(posedge pclk) begin
      if (link.mem_ack === 1'b1 && link.mem_per === 1'b0)
         sram_q.push_back(link.mem_addr);
      for (int c = 0; c < NCH; c++)
         if (blk_done[c] === 1'b1)
            done_cnt[c]++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16) begin
         num_errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_tx();
      int n;
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (tx_stb === 1'b1)
            break;
      end
      if (n == 40) begin
         num_errors++;
         conclude();
      end
   endtask

   // Enable written last so the channel never runs half set up
   task automatic cfg(input int c, input logic [7:0] ctl, input logic [7:0] sel,
                      input logic [15:0] pad, input logic [13:0] cnt);
      logic [7:0] b;
      b = 8'(c * 32);
      apb(1'b1, b + OFF_REQ, {24'h0, sel});
      apb(1'b1, b + OFF_STA, {16'h0, sa});
      apb(1'b1, b + OFF_STB, {16'h0, sb});
      apb(1'b1, b + OFF_PAD, {16'h0, pad});
      apb(1'b1, b + OFF_CNT, {18'h0, cnt});
      apb(1'b1, b + OFF_CTRL, {24'h0, ctl});
   endtask

   task automatic fire(input logic [7:0] code);
      @(posedge pclk);
      ev[code] <= 1'b1;
      @(posedge pclk);
      ev <= '0;
   endtask

   function automatic logic [15:0] exp_addr(logic [7:0] ctl, int cnt, int i);
      logic [15:0] base;
      base = (ctl[CF_PP] && (i / (cnt + 1)) % 2 == 1) ? sb : sa;
      if (ctl[CF_AM+:2] == AM_PIA)
         base = base + pia[0];
      if (ctl[CF_AM+:2] == AM_HOLD)
         return base;
      return base + 16'((i % (cnt + 1)) * (ctl[CF_BYTE] ? 1 : 2));
   endfunction

   function automatic int exp_irq(logic [7:0] ctl, int cnt, int n);
      int k;
      k = 0;
      for (int i = 0; i < n; i++)
         if (i % (cnt + 1) == (ctl[CF_HALF] ? cnt / 2 : cnt))
            k++;
      return k;
   endfunction

   initial begin
      seed = 98544;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = '0;
      ld = 1'b0;
      ld_addr = 16'h0;
      ld_data = 16'h0;
      pia = '{default: 16'h0};
      sb = 16'h0;
      num_errors = 0;
      check_count = 0;
      done_cnt = '{default: 0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset value, unmapped place, random field readback
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, {24'h0, CTRL_RST});
      apb(1'b1, 8'h18, 32'hffffffff);
      chk({31'h0, err}, 32'h1);
      for (int c = 0; c < NCH; c++) begin
         v = $random(seed);
         apb(1'b1, 8'(c * 32) + OFF_REQ, v & 32'h7fff);
         apb(1'b0, 8'(c * 32) + OFF_REQ, 32'h0);
         chk(rd, {24'h0, v[7:0]});
      end
      $display("register test done");
      // Every peripheral code: into SRAM, then back out
      for (int j = 0; j < 4; j++) begin
         tx = (j < 3) ? 2 * j + 1 : 1;
         sa = 16'($random(seed)) & 16'h0ffe;
         dat = 16'($random(seed));
         cfg(0, 8'h01, PER_CODE[2 * j], PER_ADDR[2 * j], 14'h0);
         @(posedge pclk);
         ld      <= 1'b1;
         ld_addr <= PER_ADDR[2 * j];
         ld_data <= dat;
         @(posedge pclk);
         ld <= 1'b0;
         repeat (10) @(posedge pclk);
         cfg(1, 8'h03, PER_CODE[tx], PER_ADDR[tx], 14'h0);
         fire(PER_CODE[tx]);
         wait_tx();
         chk(32'(tx_addr), 32'(PER_ADDR[tx]));
         chk(32'(tx_data), 32'(dat));
      end
      $display("peripheral code test done");
      // Two channels on one event: lower number goes first
      sa = 16'h0100;
      cfg(2, 8'h03, SEL_EXT0, ADR_S1_TX, 14'h0);
      cfg(3, 8'h03, SEL_EXT0, ADR_S2_TX, 14'h0);
      fire(SEL_EXT0);
      wait_tx();
      chk(32'(tx_addr), 32'(ADR_S1_TX));
      wait_tx();
      chk(32'(tx_addr), 32'(ADR_S2_TX));
      $display("priority test done");
      // Block modes driven by forced requests
      for (int r = 0; r < 5; r++) begin
         sa = 16'($random(seed)) & 16'h0ffe;
         sb = 16'($random(seed)) & 16'h0ffe;
         pia[0] <= 16'($random(seed)) & 16'h0ffe;
         cfg(0, TCTL[r], SEL_EXT0, ADR_S1_TX, 14'(TCNT[r]));
         // Sticky flags cleared by writing ones
         apb(1'b1, OFF_STAT, 32'hff);
         apb(1'b0, OFF_STAT, 32'h0);
         chk({24'h0, rd[7:0]}, 32'h0);
         sram_q.delete();
         done_cnt = '{default: 0};
         for (int q = 0; q < TREQ[r]; q++) begin
            apb(1'b1, OFF_REQ, 32'h8000);
            repeat (8) @(posedge pclk);
         end
         ntr = (TCTL[r][CF_RPT] || TREQ[r] <= TCNT[r]) ? TREQ[r] : TCNT[r] + 1;
         chk(32'(sram_q.size()), 32'(ntr));
         for (int i = 0; i < ntr && i < sram_q.size(); i++)
            chk(32'(sram_q[i]), 32'(exp_addr(TCTL[r], TCNT[r], i)));
         chk(32'(done_cnt[0]), 32'(exp_irq(TCTL[r], TCNT[r], ntr)));
         apb(1'b0, OFF_STAT, 32'h0);
         chk(rd, {20'h0, 3'h0, TCTL[r][CF_PP] && (ntr / (TCNT[r] + 1)) % 2 == 1,
                  3'h0, ntr > TCNT[r] / 2, 3'h0, ntr > TCNT[r]});
         $display("block mode test %0d done", r);
      end
      conclude();
   end
endmodule // dmx_ctrl_test
